/* src/sar_adc_start_and_bus_control.sv */
// Start, successive-approximation sequencing and bus control of an 8-bit converter.
// Assumes the external converter clock is clk_sys_in and that the analog ladder and
// comparator sit outside, driven by trial_code_out and answering on compare_in.
// Functional notes
// - MSB first, eight steps, sixty-four clocks
// - Latch binary result, then assert done low
// - New start aborts running conversion
// - Done fed to start gives continuous conversion
// - Start strobe fall clears register and chain
// - Select and strobe low hold reset
// - Search begins one to eight clocks later
// - Start flag clears chain and done flag
// - Flag clears on tick without start condition
// - Result moves to latch before done flag
// - Done set pulse lasts eight clocks
// - Continuous mode shrinks done pulse
// - Select and read clear done, drive data
// - All three controls are active low
// - Negative input sampled 4.5 clocks later (strobe here comes 4 clocks after the positive one)
// - Reversed inputs give all-zero code
// - Asynchronous start latched, waits for phase
`include "sar_ctl_consts.svh"
`default_nettype none
module sar_adc_start_and_bus_control #(
  parameter int RESULT_BITS = `SAR_RESULT_BITS
) (
  input wire logic clk_sys_in, // External converter clock
  input wire logic reset_n_in, // Synchronous reset, active low
  input wire logic chip_select_n_in, // Chip select pin
  input wire logic start_n_in, // Start strobe pin (write)
  input wire logic read_n_in, // Read strobe pin
  input wire logic compare_in, // Comparator: input at or above trial code
  input wire logic inputs_reversed_in, // Negative input at or above positive
  output logic [RESULT_BITS-1:0] trial_code_out, // Code driving the ladder
  output logic sample_pos_out, // Pulse: sample positive input
  output logic sample_neg_out, // Pulse: sample negative input
  output logic [RESULT_BITS-1:0] data_out, // Result latch onto data pins
  output logic data_oe_out, // Data pins driven while high
  output logic conversion_done_n_out // Completion output, active low
);
  // Pin synchronisers; idle high because every control is active low
  logic [2:0] cs_sync; // Chip select stages
  logic [2:0] wr_sync; // Start strobe stages
  logic [2:0] rd_sync; // Read strobe stages
  logic cs_n; // Settled chip select
  logic wr_n; // Settled start strobe
  logic rd_n; // Settled read strobe
  logic wr_n_prev; // Strobe one cycle ago for edge detect
  // Sequencer
  sar_ctl_pkg::seq_state_type state; // Start flag and search state
  logic [`SAR_PHASE_BITS-1:0] phase; // Internal clock phase, ext clock / 8
  logic [RESULT_BITS-1:0] approximation_register; // Trial bits
  logic [RESULT_BITS-1:0] token_chain; // One-hot sequencing shift register
  logic [RESULT_BITS-1:0] result_latch; // Output latch
  logic [3:0] set_count; // Remaining cycles of the done set pulse
  logic done_flag; // Completion flag
  logic [2:0] neg_gap; // Cycles until the negative sample
  logic cmp_s1; // Comparator first stage
  logic cmp_s2; // Comparator second stage
  logic cmp_s3; // Comparator third stage
  logic compare; // Settled comparator level
  logic rev_s1; // Reversed-input first stage
  logic rev_s2; // Reversed-input second stage
  logic rev_s3; // Reversed-input third stage
  logic reversed; // Settled reversed-input level

  // A level only moves once the last two stages agree, filtering glitches
  function automatic logic settle(input logic prev, input logic s2, input logic s3);
    settle = (s2 == s3) ? s3 : prev;
  endfunction

  // Decoded conditions; strobe ones from settled levels, tick from the phase
  wire start_cond = !cs_n && !wr_n;
  wire read_cond = !cs_n && !rd_n;
  wire wr_fall = wr_n_prev && !wr_n;
  wire tick = (phase == `SAR_PHASE_LAST); // Internal clock edge
  wire launch = (state == sar_ctl_pkg::st_start) && tick && !start_cond;
  wire step = (state == sar_ctl_pkg::st_search) && tick;
  wire finish = step && token_chain[0];
  // Keep the tested bit only if the input is at or above the trial code
  wire [RESULT_BITS-1:0] kept = compare ? approximation_register : (approximation_register & ~token_chain);
  wire [RESULT_BITS-1:0] final_code = reversed ? `SAR_ZERO_CODE : kept;

  // Three-stage pin synchronisers
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cs_sync <= `SAR_PIN_IDLE;
      wr_sync <= `SAR_PIN_IDLE;
      rd_sync <= `SAR_PIN_IDLE;
      {cmp_s1, cmp_s2, cmp_s3} <= 3'h0;
      {rev_s1, rev_s2, rev_s3} <= 3'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], chip_select_n_in};
      wr_sync <= {wr_sync[1:0], start_n_in};
      rd_sync <= {rd_sync[1:0], read_n_in};
      {cmp_s3, cmp_s2, cmp_s1} <= {cmp_s2, cmp_s1, compare_in};
      {rev_s3, rev_s2, rev_s1} <= {rev_s2, rev_s1, inputs_reversed_in};
    end
  end

  // Settled levels
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n_prev <= 1'b1;
      compare <= 1'b0;
      reversed <= 1'b0;
    end else begin
      cs_n <= settle(cs_n, cs_sync[1], cs_sync[2]);
      wr_n <= settle(wr_n, wr_sync[1], wr_sync[2]);
      rd_n <= settle(rd_n, rd_sync[1], rd_sync[2]);
      wr_n_prev <= wr_n;
      compare <= settle(compare, cmp_s2, cmp_s3);
      reversed <= settle(reversed, rev_s2, rev_s3);
    end
  end

  // Free-running internal phase; its position gives the 1..8 clock start delay
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // Start flag and search sequencer
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state <= sar_ctl_pkg::st_idle;
      approximation_register <= `SAR_ZERO_CODE;
      token_chain <= `SAR_ZERO_CODE;
    end else if (start_cond) begin
      // Held here for any pulse width; also aborts a running search
      state <= sar_ctl_pkg::st_start;
      approximation_register <= `SAR_ZERO_CODE;
      token_chain <= `SAR_ZERO_CODE;
    end else if (wr_fall) begin
      // Strobe fall without select still clears the search
      state <= sar_ctl_pkg::st_idle;
      approximation_register <= `SAR_ZERO_CODE;
      token_chain <= `SAR_ZERO_CODE;
    end else if (launch) begin
      // Flag clears only on a tick after the start condition is gone
      state <= sar_ctl_pkg::st_search;
      approximation_register <= `SAR_MSB_MASK;
      token_chain <= `SAR_MSB_MASK;
    end else if (finish) begin
      state <= sar_ctl_pkg::st_report;
      approximation_register <= final_code;
      token_chain <= `SAR_ZERO_CODE;
    end else if (step) begin
      // Decide this bit, then try the next lower one
      approximation_register <= kept | (token_chain >> 1);
      token_chain <= token_chain >> 1;
    end else if (state == sar_ctl_pkg::st_report && set_count == 4'h1) begin
      state <= sar_ctl_pkg::st_idle;
    end
  end

  // Result latch and done flag; set wins over the read clear
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      result_latch <= `SAR_ZERO_CODE;
      set_count <= 4'h0;
      done_flag <= 1'b0;
    end else begin
      if (finish) begin
        result_latch <= final_code;
      end
      if (start_cond || wr_fall) begin
        set_count <= 4'h0;
      end else if (finish) begin
        set_count <= `SAR_SET_PULSE;
      end else if (set_count != 4'h0) begin
        set_count <= set_count - 4'h1;
      end
      if (start_cond) begin
        done_flag <= 1'b0;
      end else if (set_count != 4'h0) begin
        done_flag <= 1'b1;
      end else if (read_cond) begin
        done_flag <= 1'b0;
      end
    end
  end

  // Analog sample strobes; the half cycle is met by the ladder on the falling edge
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      sample_pos_out <= 1'b0;
      sample_neg_out <= 1'b0;
      neg_gap <= 3'h0;
    end else begin
      sample_pos_out <= launch;
      sample_neg_out <= (neg_gap == 3'h1);
      if (launch) begin
        neg_gap <= 3'(`SAR_SAMPLE_GAP_CYCLES);
      end else if (neg_gap != 3'h0) begin
        neg_gap <= neg_gap - 3'h1;
      end
    end
  end

  // Pin outputs; data only driven during a selected read
  assign trial_code_out = approximation_register;
  assign data_out = result_latch;
  assign data_oe_out = read_cond;
  assign conversion_done_n_out = !done_flag;

  // Helper: cycles since the search began
  logic [6:0] conv_cycles;
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in || launch) begin
      conv_cycles <= 7'h0;
    end else if (conv_cycles != 7'h7F) begin
      conv_cycles <= conv_cycles + 7'h1;
    end
  end

  conv_length_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    finish |-> conv_cycles == 7'(`SAR_CONV_CYCLES - 1))
    else $error("search did not take sixty-four clocks");

  latch_before_done_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    finish && !start_cond ##1 !start_cond |-> data_out == $past(final_code) ##1 !conversion_done_n_out)
    else $error("result not latched before done asserted");

  done_width_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    $fell(conversion_done_n_out) && !start_cond |-> (!conversion_done_n_out || start_cond)[*8])
    else $error("done pulse shorter than eight clocks");

  hold_reset_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    start_cond |=> state == sar_ctl_pkg::st_start && token_chain == 8'h00)
    else $error("search progressed during start condition");

  start_delay_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    state == sar_ctl_pkg::st_start && !start_cond ##1 (!start_cond)[*8] |-> state != sar_ctl_pkg::st_start)
    else $error("search did not begin within eight clocks");

  start_clears_done_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    start_cond |=> conversion_done_n_out)
    else $error("start did not clear done");

  read_drives_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    cs_sync[2:1] == 2'b00 && rd_sync[2:1] == 2'b00 |=> data_oe_out)
    else $error("data enable does not follow select and read");

  read_clears_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    read_cond && set_count == 4'h0 && !start_cond |=> conversion_done_n_out)
    else $error("read did not clear done");

  neg_sample_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    sample_pos_out |-> ##4 sample_neg_out)
    else $error("negative sample not four clocks after positive");

  zero_code_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    finish && reversed |=> data_out == 8'h00)
    else $error("reversed inputs gave nonzero code");

  wr_fall_clear_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_fall |=> approximation_register == 8'h00 && token_chain == 8'h00)
    else $error("strobe fall did not clear search");

  // The latch only moves at the end of a search, so a read sees the last result
  latch_hold_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !finish |=> $stable(data_out))
    else $error("output latch changed without a finished search");
endmodule
`default_nettype wire

/* src/sar_ctl_consts.svh */
// Constants of the converter start, search and bus control block.
// Assumes one system clock of 50 ns; counts are in its cycles, the sample gap in half cycles.
`ifndef SAR_CTL_CONSTS_SVH
`define SAR_CTL_CONSTS_SVH
`define SAR_CLK_PERIOD_NS 50
`define SAR_RESULT_BITS 8
`define SAR_PHASE_BITS 3
`define SAR_PHASE_LAST 3'h7
`define SAR_STEPS 8
`define SAR_CONV_CYCLES 64
`define SAR_SET_PULSE 4'h8
`define SAR_MSB_MASK 8'h80
`define SAR_LSB_MASK 8'h01
`define SAR_ZERO_CODE 8'h00
`define SAR_FULL_SCALE 8'hFF
`define SAR_PIN_IDLE 3'h7
`define SAR_SAMPLE_GAP_HALVES 9
`define SAR_SAMPLE_GAP_CYCLES (`SAR_SAMPLE_GAP_HALVES / 2)
`define SAR_DONE_PULSE_NS 300
`define SAR_DONE_PULSE_CYCLES (`SAR_DONE_PULSE_NS / `SAR_CLK_PERIOD_NS)
`endif

/* src/sar_ctl_pkg.sv */
// Types of the converter start, search and bus control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sar_ctl_pkg;
  // Sequencer states; st_start is the internal start flag being set
  typedef enum logic [1:0] {st_idle, st_start, st_search, st_report} seq_state_type;
endpackage
`default_nettype wire

/* verification/host_bus_model.sv */
// Host side of the converter bus: drives select, start and read strobes.
// Assumes the converter clock; pins change 5 ns after its rising edge.
`default_nettype none
module host_bus_model (
  input wire logic clk_sys_in, // Converter clock
  input wire logic done_n_in, // Completion output fed back
  input wire logic continuous_in, // Loop completion into start
  output logic chip_select_n_out, // Select, active low
  output logic start_n_out, // Start strobe, active low
  output logic read_n_out // Read strobe, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel_n; // Own select level
  logic write_n; // Own start level
  logic rd_n; // Own read level
  // All strobes idle high from time zero
  initial begin
    sel_n = 1'b1;
    write_n = 1'b1;
    rd_n = 1'b1;
  end
  // Free-running loop ties select low and done to start
  assign chip_select_n_out = continuous_in ? 1'b0 : sel_n;
  assign start_n_out = continuous_in ? done_n_in : write_n;
  assign read_n_out = rd_n;
  // Start pulse; select stays low afterwards only while reading
  task automatic pulse_start(input int n);
    @(posedge clk_sys_in) #5;
    sel_n = 1'b0;
    write_n = 1'b0;
    repeat (n) @(posedge clk_sys_in);
    #5;
    write_n = 1'b1;
    sel_n = rd_n;
  endtask
  // Strobe alone with select high: clears a search, starts nothing
  task automatic pulse_strobe_only(input int n);
    @(posedge clk_sys_in) #5;
    write_n = 1'b0;
    repeat (n) @(posedge clk_sys_in);
    #5;
    write_n = 1'b1;
  endtask
  // Read access holds select and read together
  task automatic set_read(input logic lvl);
    @(posedge clk_sys_in) #5;
    sel_n = lvl;
    rd_n = lvl;
  endtask
endmodule
`default_nettype wire

/* verification/test_sar_adc_start_and_bus_control.sv */
// Self-checking bench of the start, search and bus control block.
// Assumes the host model on the strobes and a comparator built from a level.
`default_nettype none
module test_sar_adc_start_and_bus_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in, reset_n_in, compare_in, inputs_reversed_in, continuous;
  wire logic chip_select_n, start_n, read_n; // Strobes from host model
  logic [7:0] trial_code_out, data_out, first_trial, level = 8'h00; // Level is the analog input
  logic sample_pos_out, sample_neg_out, data_oe_out, conversion_done_n_out, prev_done = 1'b1;
  int fail_count = 0, n_compared = 0, cyc = 0, pos_t = 0, neg_t = 0, lo_run = 0, last_w = 0, max_w = 0, falls = 0;
  sar_adc_start_and_bus_control dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .chip_select_n_in(chip_select_n), .start_n_in(start_n), .read_n_in(read_n), .compare_in(compare_in),
    .inputs_reversed_in(inputs_reversed_in), .trial_code_out(trial_code_out), .sample_pos_out(sample_pos_out),
    .sample_neg_out(sample_neg_out), .data_out(data_out), .data_oe_out(data_oe_out),
    .conversion_done_n_out(conversion_done_n_out));
  host_bus_model host (.clk_sys_in(clk_sys_in), .done_n_in(conversion_done_n_out), .continuous_in(continuous),
    .chip_select_n_out(chip_select_n), .start_n_out(start_n), .read_n_out(read_n));
  // 20 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // Comparator: input at or above the trial code
  always @(posedge clk_sys_in) begin
    compare_in <= #5 (level >= trial_code_out);
  end
  // Cycle count, hang guard, sample strobes and done pulse widths
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
    if (sample_pos_out === 1'b1) begin
      pos_t = cyc;
      first_trial = trial_code_out;
    end
    if (sample_neg_out === 1'b1) neg_t = cyc;
    if (prev_done === 1'b1 && conversion_done_n_out === 1'b0) falls++;
    prev_done = conversion_done_n_out;
    if (conversion_done_n_out === 1'b0) begin
      lo_run++;
    end else begin
      if (lo_run > 0) last_w = lo_run;
      if (lo_run > max_w) max_w = lo_run;
      lo_run = 0;
    end
  end
  task automatic check(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wait_done(output int c);
    c = 0;
    while (conversion_done_n_out !== 1'b0 && c < 200) begin
      @(posedge clk_sys_in) #1;
      c++;
    end
  endtask
  // Read while done has settled, then release and watch the pins float
  task automatic read_result(input logic [7:0] exp);
    host.set_read(1'b0);
    repeat (12) @(posedge clk_sys_in);
    #1;
    check(data_oe_out === 1'b1 && data_out === exp && conversion_done_n_out === 1'b1, "read");
    host.set_read(1'b1);
    repeat (6) @(posedge clk_sys_in);
    #1;
    check(data_oe_out === 1'b0 && data_out === exp, "float or latch");
  endtask
  // One conversion with a start pulse of w cycles
  task automatic convert(input logic [7:0] lvl, input logic rev, input int w, input logic [7:0] exp);
    int c;
    int p;
    p = pos_t;
    level = lvl;
    inputs_reversed_in = rev;
    host.pulse_start(w);
    check(pos_t == p && conversion_done_n_out === 1'b1, "held in reset");
    wait_done(c);
    check(c >= 64 && c <= 82, "done latency");
    check(first_trial === 8'h80 && neg_t - pos_t == 4, "msb first or sample gap");
    check(data_out === exp, "result at done");
    read_result(exp);
  endtask
  // A second start in mid-search replaces the first conversion
  task automatic abort_restart;
    level = 8'h3C;
    host.pulse_start(6);
    repeat (30) @(posedge clk_sys_in);
    check(conversion_done_n_out === 1'b1, "early done");
    convert(8'hC3, 1'b0, 6, 8'hC3);
  endtask
  // Strobe fall without select stops the search and no done follows
  task automatic strobe_clears;
    int c;
    level = 8'h99;
    host.pulse_start(6);
    repeat (30) @(posedge clk_sys_in);
    host.pulse_strobe_only(2);
    repeat (6) @(posedge clk_sys_in);
    #1;
    check(trial_code_out === 8'h00, "strobe fall clear");
    wait_done(c);
    check(c == 200 && conversion_done_n_out === 1'b1, "no done after clear");
  endtask
  // Outputs enabled throughout: done still pulses for the set time
  task automatic read_held;
    int c;
    host.set_read(1'b0);
    level = 8'h81;
    host.pulse_start(6);
    wait_done(c);
    repeat (14) @(posedge clk_sys_in);
    #1;
    check(last_w >= 8 && last_w <= 10 && data_out === 8'h81, "set pulse");
    host.set_read(1'b1);
  endtask
  // Done looped to start: repeated short done pulses
  task automatic continuous_run;
    level = 8'h42;
    host.pulse_start(6);
    continuous = 1'b1;
    falls = 0;
    max_w = 0;
    repeat (400) @(posedge clk_sys_in);
    #5;
    continuous = 1'b0;
    check(falls >= 4 && max_w >= 1 && max_w <= 6, "free run");
    repeat (100) @(posedge clk_sys_in);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence after a 6-cycle reset
  initial begin
    reset_n_in = 1'b0;
    inputs_reversed_in = 1'b0;
    continuous = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    #5;
    reset_n_in = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    #1;
    check(conversion_done_n_out === 1'b1 && data_oe_out === 1'b0 && data_out === 8'h00, "reset state");
    convert(8'hA5, 1'b0, 6, 8'hA5);
    convert(8'hFF, 1'b0, 6, 8'hFF);
    convert(8'h5A, 1'b1, 6, 8'h00);
    convert(8'h66, 1'b0, 200, 8'h66);
    abort_restart();
    strobe_clears();
    read_held();
    continuous_run();
    wrap_up();
  end
endmodule
`default_nettype wire
